/* rtl/ballast_pkg.sv */
// Purpose: Shared constants and types for the discharge-lamp ballast sequencer.
// Assumes: 20 MHz system clock; comparator results arrive as plain levels.
// Notes:   Strike timing counts ramp-oscillator ticks, not system clocks.
package ballast_pkg;

   // ==========================================================
   // Clock and dead-time
   localparam int CLK_PERIOD_NS = 50;
   localparam int DEAD_TIME_NS  = 1000;
   localparam int DEAD_CYC      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEAD_W        = 8;
   localparam logic [DEAD_W-1:0] DEAD_LAST = DEAD_W'(DEAD_CYC - 1);

   // ==========================================================
   // Strike timer, in ticks of the strike ramp oscillator
   localparam int STRIKE_BASE_MS  = 666;
   localparam int STRIKE_DIV      = 128;
   localparam int STRIKE_ON_MS    = 21000;
   localparam int STRIKE_OFF_MS   = 64000;
   localparam int STRIKE_FAULT_MS = 787000;
   localparam int STRIKE_ON_TICKS =
      (STRIKE_ON_MS * STRIKE_DIV + (STRIKE_ON_MS + STRIKE_OFF_MS) / 2)
      / (STRIKE_ON_MS + STRIKE_OFF_MS);
   localparam int STRIKE_FAULT_TICKS = STRIKE_FAULT_MS / STRIKE_BASE_MS;
   localparam int DIV_W  = $clog2(STRIKE_DIV);
   localparam int TICK_W = 12;

   // ==========================================================
   // Fast lamp under-voltage event limit
   localparam int EVENT_LIMIT = 16384;
   localparam int EVENT_W     = 15;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      ST_LOCKOUT = 4'h1,
      ST_STRIKE  = 4'h2,
      ST_RUN     = 4'h4,
      ST_FAULT   = 4'h8
   } mode_e;

   typedef struct packed {
      logic supply_ok;          // Supply above start threshold
      logic fault_clear_low;    // Fault-clear pin below its low threshold
      logic lamp_voltage_low;   // Lamp voltage below strike-detect level
      logic strike_ramp_top;    // Strike timer ramp at upper level
      logic bridge_ramp_top;    // Bridge ramp at upper level
      logic zero_cross_high;    // Buck inductor winding above its threshold
      logic off_time_max;       // Buck maximum off-time reached
      logic ramp_above_power;   // On-time ramp above power loop filter
      logic ramp_above_current; // On-time ramp above current loop filter
      logic cs_over;            // Buck current sense above its limit
      logic voltage_limit;      // Lamp voltage above its limit setpoint
      logic uv_event;           // Lamp voltage under-voltage level
   } sense_s;

   localparam int SENSE_W = $bits(sense_s);

   typedef struct packed {
      logic high_a;
      logic low_a;
      logic high_b;
      logic low_b;
   } bridge_s;

endpackage : ballast_pkg

/* rtl/comparator_sync.sv */
// Purpose: Two-stage synchroniser for a group of comparator levels.
// Assumes: One clock; inputs may change at any time.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/100ps
module comparator_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   // Levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("comparator_sync needs at least one bit");
   end

   // ==========================================================
   // One pair of flops per bit
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge i_clock or posedge i_reset) begin
         if (i_reset) begin
            stage1_r[b] <= 1'b0;
            stage2_r[b] <= 1'b0;
         end else begin
            stage1_r[b] <= i_async[b];
            stage2_r[b] <= stage1_r[b];
         end
      end
   end

   assign o_sync = stage2_r;

   a_sync_two_stage: assert property (@(posedge i_clock) disable iff (i_reset)
      ##2 (o_sync == $past(i_async, 2)))
      else $error("synchroniser output is not the input two cycles earlier");

endmodule : comparator_sync

/* rtl/ballast_sequencer.sv */
// Purpose: Mode sequencing, strike timer, bridge commutation and buck gate.
// Assumes: Comparator levels arrive on i_sense; ramp tops are levels that
//          pulse high once per oscillator cycle.
// Notes:   Gate outputs are registered; lockout clears every counter.
`timescale 1ns/100ps

module ballast_sequencer #(
   parameter int FAULT_TICKS = ballast_pkg::STRIKE_FAULT_TICKS,
   parameter int EVENT_MAX   = ballast_pkg::EVENT_LIMIT
) (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_reset,
   // Comparator results
   input  wire ballast_pkg::sense_s i_sense,
   // Gate commands
   output ballast_pkg::bridge_s    o_bridge,
   output logic                    o_buck_gate,
   output logic                    o_striker_gate_out,
   // Status
   output ballast_pkg::mode_e      o_mode
);
   import ballast_pkg::*;

   localparam int A_DEAD_SPAN = DEAD_CYC + 2;

   // ==========================================================
   // Parameter checks
   if (FAULT_TICKS < 1 || FAULT_TICKS >= (1 << TICK_W)) begin : g_bad_ticks
      $error("FAULT_TICKS does not fit the strike tick counter");
   end
   if (EVENT_MAX < 1 || EVENT_MAX >= (1 << EVENT_W)) begin : g_bad_events
      $error("EVENT_MAX does not fit the event counter");
   end

   // ==========================================================
   // Synchronised inputs and edge detection
   logic [SENSE_W-1:0] sense_raw;
   sense_s             sense;
   sense_s             sense_d_r;
   logic               strike_tick;
   logic               bridge_top;
   logic               zx_fall;
   logic               uv_rise;

   comparator_sync #(
      .WIDTH (SENSE_W)
   ) u_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_async (i_sense),
      .o_sync  (sense_raw)
   );

   assign sense = sense_s'(sense_raw);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         sense_d_r <= '0;
      end else begin
         sense_d_r <= sense;
      end
   end

   assign strike_tick = sense.strike_ramp_top & ~sense_d_r.strike_ramp_top;
   assign bridge_top  = sense.bridge_ramp_top & ~sense_d_r.bridge_ramp_top;
   assign zx_fall     = ~sense.zero_cross_high & sense_d_r.zero_cross_high;
   assign uv_rise     = sense.uv_event & ~sense_d_r.uv_event;

   // ==========================================================
   // Mode state machine
   mode_e                mode_r;
   mode_e                mode_nxt;
   logic [TICK_W-1:0]    tick_total_r;
   logic [DIV_W-1:0]     div_cnt_r;
   logic [EVENT_W-1:0]   event_cnt_r;
   logic                 exit_ok;
   logic                 strike_expire;
   logic                 event_full;
   logic                 active_nxt;

   assign exit_ok       = sense.supply_ok & sense.fault_clear_low;
   assign strike_expire = strike_tick && (tick_total_r == TICK_W'(FAULT_TICKS - 1));
   assign event_full    = uv_rise && (event_cnt_r == EVENT_W'(EVENT_MAX - 1));

   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         ST_LOCKOUT: begin
            if (exit_ok) begin
               mode_nxt = ST_STRIKE;
            end
         end
         ST_STRIKE: begin
            if (sense.lamp_voltage_low) begin
               mode_nxt = ST_RUN;
            end else if (strike_expire) begin
               mode_nxt = ST_FAULT;
            end
         end
         ST_RUN: begin
            if (event_full) begin
               mode_nxt = ST_FAULT;
            end
         end
         ST_FAULT: begin
            mode_nxt = ST_FAULT;
         end
         default: begin
            mode_nxt = ST_LOCKOUT;
         end
      endcase
      // Supply loss overrides every mode, including a latched fault
      if (!sense.supply_ok) begin
         mode_nxt = ST_LOCKOUT;
      end
   end

   assign active_nxt = (mode_nxt == ST_STRIKE) || (mode_nxt == ST_RUN);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         mode_r <= ST_LOCKOUT;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ==========================================================
   // Strike timer: runs only while striking, zero otherwise
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         tick_total_r <= '0;
         div_cnt_r    <= '0;
      end else if (mode_nxt != ST_STRIKE || mode_r != ST_STRIKE) begin
         tick_total_r <= '0;
         div_cnt_r    <= '0;
      end else if (strike_tick) begin
         tick_total_r <= tick_total_r + 1'b1;
         div_cnt_r    <= div_cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // Fault event counter
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         event_cnt_r <= '0;
      end else if (mode_nxt == ST_LOCKOUT) begin
         event_cnt_r <= '0;
      end else if (mode_r == ST_RUN && uv_rise) begin
         event_cnt_r <= event_cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // Bridge commutation with dead-time
   logic              phase_r;
   logic              phase_nxt;
   logic              dead_r;
   logic              dead_nxt;
   logic [DEAD_W-1:0] dead_cnt_r;
   logic [DEAD_W-1:0] dead_cnt_nxt;
   logic              bridge_start;
   logic              swap;
   bridge_s           bridge_r;
   bridge_s           pair_nxt;

   assign bridge_start = (mode_r == ST_LOCKOUT) && active_nxt;
   assign swap         = bridge_top && active_nxt && !bridge_start;

   always_comb begin
      phase_nxt    = phase_r;
      dead_nxt     = dead_r;
      dead_cnt_nxt = dead_cnt_r;
      if (!active_nxt) begin
         phase_nxt    = 1'b0;
         dead_nxt     = 1'b0;
         dead_cnt_nxt = '0;
      end else if (bridge_start || swap) begin
         phase_nxt    = swap ? ~phase_r : 1'b0;
         dead_nxt     = 1'b1;
         dead_cnt_nxt = '0;
      end else if (dead_r) begin
         dead_cnt_nxt = dead_cnt_r + 1'b1;
         if (dead_cnt_r == DEAD_LAST) begin
            dead_nxt = 1'b0;
         end
      end
   end

   always_comb begin
      pair_nxt = '0;
      if (active_nxt && !dead_nxt) begin
         pair_nxt.high_a = ~phase_nxt;
         pair_nxt.low_b  = ~phase_nxt;
         pair_nxt.high_b = phase_nxt;
         pair_nxt.low_a  = phase_nxt;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         phase_r    <= 1'b0;
         dead_r     <= 1'b0;
         dead_cnt_r <= '0;
         bridge_r   <= '0;
      end else begin
         phase_r    <= phase_nxt;
         dead_r     <= dead_nxt;
         dead_cnt_r <= dead_cnt_nxt;
         bridge_r   <= pair_nxt;
      end
   end

   // ==========================================================
   // Striker gate: on-window of each divided cycle, never in dead-time
   logic striker_r;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         striker_r <= 1'b0;
      end else begin
         striker_r <= (mode_nxt == ST_STRIKE) && (mode_r == ST_STRIKE)
                      && (div_cnt_r < DIV_W'(STRIKE_ON_TICKS))
                      && !dead_nxt && (pair_nxt != '0);
      end
   end

   // ==========================================================
   // Buck gate: restart on zero crossing or maximum off-time
   logic buck_r;
   logic buck_end;

   // Either comparator firing means the ramp passed the lower filter voltage
   assign buck_end = sense.ramp_above_power | sense.ramp_above_current
                     | sense.cs_over | sense.voltage_limit;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         buck_r <= 1'b0;
      end else if (!active_nxt) begin
         buck_r <= 1'b0;
      end else if (buck_r && buck_end) begin
         buck_r <= 1'b0;
      end else if (!buck_r && (zx_fall || sense.off_time_max) && !buck_end) begin
         buck_r <= 1'b1;
      end
   end

   assign o_bridge           = bridge_r;
   assign o_buck_gate        = buck_r;
   assign o_striker_gate_out = striker_r;
   assign o_mode             = mode_r;

   // ==========================================================
   // Checks
   logic active_r;
   assign active_r = (mode_r == ST_STRIKE) || (mode_r == ST_RUN);

   sequence s_swap_seen;
      swap && (mode_r == ST_STRIKE || mode_r == ST_RUN);
   endsequence

   sequence s_gates_dark;
      (o_bridge == '0)[*8];
   endsequence

   a_lockout_all_off: assert property (@(posedge i_clock) disable iff (i_reset)
      (mode_r == ST_LOCKOUT) |-> (o_bridge == '0) && !o_buck_gate && !o_striker_gate_out
         && (tick_total_r == '0) && (event_cnt_r == '0))
      else $error("outputs or counters active in lockout");

   a_exit_needs_clear: assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(mode_r == ST_STRIKE) |-> $past(exit_ok))
      else $error("lockout left without supply and low fault-clear pin");

   a_timer_from_zero: assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(mode_r == ST_STRIKE) |-> (tick_total_r == '0) && (div_cnt_r == '0))
      else $error("strike timer not zero on entry");

   a_striker_window: assert property (@(posedge i_clock) disable iff (i_reset)
      o_striker_gate_out |-> ($past(div_cnt_r) < DIV_W'(STRIKE_ON_TICKS)))
      else $error("striker gate on outside its on-window");

   a_strike_timeout: assert property (@(posedge i_clock) disable iff (i_reset)
      (mode_r == ST_STRIKE && strike_expire && sense.supply_ok && !sense.lamp_voltage_low)
         |=> (mode_r == ST_FAULT) ##1 (mode_r == ST_FAULT || mode_r == ST_LOCKOUT))
      else $error("strike timeout did not latch fault");

   a_ignited_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
      (mode_r == ST_RUN) |-> !o_striker_gate_out && (tick_total_r == '0))
      else $error("striker active after ignition");

   a_bridge_starts: assert property (@(posedge i_clock) disable iff (i_reset)
      $rose(mode_r == ST_STRIKE) |-> ##[1:A_DEAD_SPAN] ((o_bridge != '0) || !active_r))
      else $error("bridge did not start after lockout");

   a_pair_swaps: assert property (@(posedge i_clock) disable iff (i_reset)
      s_swap_seen |=> (phase_r != $past(phase_r)))
      else $error("bridge pair not swapped at ramp top");

   a_dead_gates_off: assert property (@(posedge i_clock) disable iff (i_reset)
      s_swap_seen |=> s_gates_dark)
      else $error("bridge gate on inside dead-time");

   a_striker_dead: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_striker_gate_out |-> (o_bridge != '0)) and (dead_r |-> !o_striker_gate_out))
      else $error("striker gate on during dead-time");

   a_bridge_halt: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_bridge != '0) |-> active_r)
      else $error("bridge driven outside strike or run");

   a_buck_ends: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_buck_gate && (sense.ramp_above_power || sense.ramp_above_current)) |=> !o_buck_gate)
      else $error("buck on-time did not end at ramp crossing");

   a_event_fault: assert property (@(posedge i_clock) disable iff (i_reset)
      (mode_r == ST_RUN && event_full && sense.supply_ok) |=> (mode_r == ST_FAULT))
      else $error("event limit did not shut down");

endmodule : ballast_sequencer

/* test/buck_sense_model.sv */
// Purpose: Far-side model of the buck stage and its sense comparators.
// Assumes: Gate command is a registered level; answers change just after a rising edge.
// Notes:   The on-time end term is picked per pulse; pick 3 runs continuous conduction.
`timescale 1ns/100ps
module buck_sense_model #(
   parameter int ON_CYC = 6
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   // Gate and choice of end term
   input  wire logic        i_buck_gate,
   input  wire logic [1:0]  i_pick,
   // Sense levels
   output logic             o_zx_high,
   output logic             o_off_time_max,
   output logic             o_ramp_above_power,
   output logic             o_ramp_above_current,
   output logic             o_cs_over,
   // Observation
   output logic [7:0]       o_max_lat,
   output logic [15:0]      o_pulses
);
   logic [5:0] on_cnt_r;
   logic [5:0] off_cnt_r;
   logic [7:0] lat_r;
   logic [1:0] sel_r;
   logic       ending_r;

   // ==========================================================
   // Power stage
   // The end term holds until the gate drops, so a slow turn-off shows as a longer latency
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         {on_cnt_r, off_cnt_r, lat_r, sel_r, ending_r} <= '0;
         {o_zx_high, o_off_time_max, o_ramp_above_power} <= 3'h0;
         {o_ramp_above_current, o_cs_over, o_max_lat, o_pulses} <= '0;
      end else if (i_buck_gate) begin
         off_cnt_r <= 6'h00;
         on_cnt_r <= on_cnt_r + 6'h01;
         o_zx_high <= 1'b0;
         o_off_time_max <= 1'b0;
         if (ending_r) lat_r <= lat_r + 8'h01;
         if (on_cnt_r == 6'(ON_CYC)) begin
            ending_r <= 1'b1;
            lat_r <= 8'h00;
            sel_r <= i_pick;
            o_ramp_above_power <= (i_pick == 2'h0) || (i_pick == 2'h3);
            o_ramp_above_current <= (i_pick == 2'h1);
            o_cs_over <= (i_pick == 2'h2);
         end
      end else begin
         on_cnt_r <= 6'h00;
         if (ending_r) begin
            ending_r <= 1'b0;
            {o_ramp_above_power, o_ramp_above_current, o_cs_over} <= 3'h0;
            o_pulses <= o_pulses + 16'h0001;
            if (lat_r > o_max_lat) o_max_lat <= lat_r;
         end
         if (off_cnt_r != 6'h3F) off_cnt_r <= off_cnt_r + 6'h01;
         // Continuous conduction never discharges to zero; the off-time limit restarts it
         o_zx_high <= (off_cnt_r < 6'h05) || (sel_r == 2'h3);
         o_off_time_max <= (off_cnt_r >= 6'h1E) || ((sel_r == 2'h3) && (off_cnt_r >= 6'h08));
      end
   end
endmodule : buck_sense_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the ballast sequencer.
// Assumes: Ramp tops are pulsed by the bench; the buck stage is modelled.
// Notes:   Fault tick and event limits are shortened through the design parameters.
`timescale 1ns/100ps
module testbench;
   import ballast_pkg::*;
   // ==========================================================
   // Setup
   localparam int FT = 150;
   localparam int EM = 3;
   localparam logic [3:0] PAIR_A = 4'h9;
   localparam logic [3:0] PAIR_B = 4'h6;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   sense_s      i_sense;
   bridge_s     o_bridge;
   logic        o_buck_gate;
   logic        o_striker_gate_out;
   mode_e       o_mode;
   mode_e       last_mode = ST_LOCKOUT;
   mode_e       exp_q[$];
   logic        supply_ok = 1'b0;
   logic        fclear_low = 1'b0;
   logic        lamp_low = 1'b0;
   logic        s_top = 1'b0;
   logic        b_top = 1'b0;
   logic        v_lim = 1'b0;
   logic        uv = 1'b0;
   logic        zx, otm, rap, rac, cso;
   logic [1:0]  pick = 2'h0;
   logic [7:0]  max_lat;
   logic [15:0] pulses;
   logic [31:0] seed = 32'h0001846D;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;

   assign i_sense = '{supply_ok, fclear_low, lamp_low, s_top, b_top, zx, otm, rap, rac, cso,
                      v_lim, uv};
   always #25 i_clock = ~i_clock;

   ballast_sequencer #(.FAULT_TICKS(FT), .EVENT_MAX(EM)) ballast_sequencer_inst (
      .i_clock(i_clock), .i_reset(i_reset), .i_sense(i_sense), .o_bridge(o_bridge),
      .o_buck_gate(o_buck_gate), .o_striker_gate_out(o_striker_gate_out), .o_mode(o_mode));
   buck_sense_model buck_sense_model_inst (
      .i_clock(i_clock), .i_reset(i_reset), .i_buck_gate(o_buck_gate), .i_pick(pick),
      .o_zx_high(zx), .o_off_time_max(otm), .o_ramp_above_power(rap),
      .o_ramp_above_current(rac), .o_cs_over(cso), .o_max_lat(max_lat), .o_pulses(pulses));

   // ==========================================================
   // Compare and closing
   task automatic cmp(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic cmp_mode(input mode_e got, input mode_e exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: mode %h expected %h", $time, got, exp);
      end
   endtask : cmp_mode

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // Mode watcher: each change takes the oldest expected mode; an unplanned change mismatches
   always @(negedge i_clock) begin
      if (!i_reset && o_mode !== last_mode) begin
         if (exp_q.size() == 0) cmp_mode(o_mode, last_mode);
         else cmp_mode(o_mode, exp_q.pop_front());
         last_mode = o_mode;
      end
   end

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         $display("MISMATCH at %0t: run too long", $time);
         conclude();
      end
   end

   // ==========================================================
   // Drivers
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic wait_mode(input mode_e m);
      int n;
      n = 0;
      while (o_mode !== m && n < 10) begin
         @(negedge i_clock);
         n++;
      end
   endtask : wait_mode

   // Strike ramp top with random spacing; also repicks the buck end term
   task automatic tick();
      @(posedge i_clock);
      s_top <= 1'b1;
      seed = xs(seed);
      pick <= seed[1:0];
      @(posedge i_clock);
      s_top <= 1'b0;
      repeat (4 + int'(seed[3:2])) @(posedge i_clock);
      @(negedge i_clock);
   endtask : tick

   task automatic enter();
      int z;
      z = 0;
      exp_q.push_back(ST_STRIKE);
      @(posedge i_clock);
      supply_ok <= 1'b1;
      fclear_low <= 1'b1;
      wait_mode(ST_STRIKE);
      while (o_bridge === 4'h0 && z < 40) begin
         z++;
         @(negedge i_clock);
      end
      cmp("entry dead-time", z, 20);
      cmp("first pair", o_bridge, PAIR_A);
      cmp("striker at first pair", o_striker_gate_out, 1'b1);
   endtask : enter

   task automatic swap(input logic [3:0] nxt, input logic stk);
      int   n;
      int   z;
      logic lit;
      n = 0;
      z = 0;
      lit = 1'b0;
      @(posedge i_clock);
      b_top <= 1'b1;
      @(posedge i_clock);
      b_top <= 1'b0;
      @(negedge i_clock);
      while (o_bridge !== 4'h0 && n < 8) begin
         @(negedge i_clock);
         n++;
      end
      while (o_bridge === 4'h0 && z < 40) begin
         if (o_striker_gate_out !== 1'b0) lit = 1'b1;
         z++;
         @(negedge i_clock);
      end
      cmp("dead-time", z, 20);
      cmp("striker in dead-time", lit, 1'b0);
      cmp("next pair", o_bridge, nxt);
      cmp("striker after dead-time", o_striker_gate_out, stk);
   endtask : swap

   // A ramp top while dark must not wake the bridge
   task automatic dark_check();
      @(posedge i_clock);
      b_top <= 1'b1;
      @(posedge i_clock);
      b_top <= 1'b0;
      repeat (30) @(negedge i_clock);
      cmp("gates dark", {o_bridge, o_buck_gate, o_striker_gate_out}, 6'h00);
   endtask : dark_check

   task automatic pulse_uv();
      @(posedge i_clock);
      uv <= 1'b1;
      @(posedge i_clock);
      uv <= 1'b0;
      repeat (5) @(negedge i_clock);
   endtask : pulse_uv

   // ==========================================================
   // Scenarios
   initial begin
      int n;
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      @(negedge i_clock);
      cmp("gates after reset", {o_bridge, o_buck_gate, o_striker_gate_out}, 6'h00);
      cmp_mode(o_mode, ST_LOCKOUT);
      $display("test reset done");
      @(posedge i_clock);
      supply_ok <= 1'b1;
      repeat (12) @(negedge i_clock);
      cmp("bridge without clear pin", o_bridge, 4'h0);
      @(posedge i_clock);
      supply_ok <= 1'b0;
      fclear_low <= 1'b1;
      repeat (12) @(negedge i_clock);
      cmp("bridge without supply", o_bridge, 4'h0);
      $display("test lockout exit done");
      enter();
      repeat (31) tick();
      cmp("striker late in on window", o_striker_gate_out, 1'b1);
      tick();
      cmp("striker after on window", o_striker_gate_out, 1'b0);
      repeat (95) tick();
      cmp("striker end of off window", o_striker_gate_out, 1'b0);
      tick();
      cmp("striker after wrap", o_striker_gate_out, 1'b1);
      repeat (FT - 129) tick();
      cmp_mode(o_mode, ST_STRIKE);
      exp_q.push_back(ST_FAULT);
      tick();
      wait_mode(ST_FAULT);
      dark_check();
      cmp_mode(o_mode, ST_FAULT);
      $display("test strike timer done");
      exp_q.push_back(ST_LOCKOUT);
      @(posedge i_clock);
      supply_ok <= 1'b0;
      wait_mode(ST_LOCKOUT);
      @(negedge i_clock);
      cmp("gates in lockout", {o_bridge, o_buck_gate, o_striker_gate_out}, 6'h00);
      enter();
      repeat (5) tick();
      swap(PAIR_B, 1'b1);
      swap(PAIR_A, 1'b1);
      exp_q.push_back(ST_RUN);
      @(posedge i_clock);
      lamp_low <= 1'b1;
      wait_mode(ST_RUN);
      repeat (2) tick();
      cmp("striker after ignition", o_striker_gate_out, 1'b0);
      swap(PAIR_B, 1'b0);
      $display("test ignition done");
      repeat (300) @(negedge i_clock);
      cmp("buck pulses", pulses > 16'h0008, 1'b1);
      cmp("on-time end latency", max_lat, 8'h03);
      @(posedge i_clock);
      v_lim <= 1'b1;
      repeat (8) @(negedge i_clock);
      n = 0;
      repeat (40) begin
         @(negedge i_clock);
         if (o_buck_gate !== 1'b0) n++;
      end
      cmp("buck held by limit", n, 0);
      @(posedge i_clock);
      v_lim <= 1'b0;
      n = 0;
      repeat (50) begin
         @(negedge i_clock);
         if (o_buck_gate === 1'b1) n = 1;
      end
      cmp("buck restarts", n, 1);
      $display("test buck done");
      repeat (EM - 1) pulse_uv();
      cmp_mode(o_mode, ST_RUN);
      exp_q.push_back(ST_FAULT);
      pulse_uv();
      wait_mode(ST_FAULT);
      dark_check();
      exp_q.push_back(ST_LOCKOUT);
      @(posedge i_clock);
      supply_ok <= 1'b0;
      lamp_low <= 1'b0;
      wait_mode(ST_LOCKOUT);
      enter();
      exp_q.push_back(ST_RUN);
      @(posedge i_clock);
      lamp_low <= 1'b1;
      wait_mode(ST_RUN);
      repeat (EM - 1) pulse_uv();
      cmp_mode(o_mode, ST_RUN);
      exp_q.push_back(ST_FAULT);
      pulse_uv();
      wait_mode(ST_FAULT);
      cmp_mode(o_mode, ST_FAULT);
      cmp("modes left unseen", exp_q.size(), 0);
      $display("test events done");
      conclude();
   end
endmodule : testbench
